// ### core/ssh_defines.vh
// constants for the subtract, special-page move and halt execution block
`ifndef SSH_DEFINES_VH
`define SSH_DEFINES_VH
// ********************************
// operation codes
// ********************************
`define SSH_OP_W 3
`define SSH_OP_NONE 3'h0
`define SSH_OP_SUB 3'h1
`define SSH_OP_PG_WR 3'h2
`define SSH_OP_PG_RD 3'h3
`define SSH_OP_HALT 3'h4
// ********************************
// status register bit positions
// ********************************
`define SSH_ST_BORROW 0
`define SSH_ST_HALF 1
`define SSH_ST_ZERO 2
`define SSH_ST_PWR 3
`define SSH_ST_EXP 4
// ********************************
// reset values
// ********************************
`define SSH_WORK_RST 8'h00
`define SSH_STATUS_RST 8'h18
`define SSH_PAGE_RST 8'h00
`define SSH_WDOG_RST 8'h00
`define SSH_DIV_RST 8'h00
// ********************************
// register offsets
// ********************************
`define SSH_A_CMD 8'h00
`define SSH_A_WORK 8'h04
`define SSH_A_STATUS 8'h08
`define SSH_A_WDOG 8'h0c
`define SSH_A_STATE 8'h10
`define SSH_A_PAGE 8'h40
// ********************************
// command register fields and the state register wake bit
// ********************************
`define SSH_CMD_IMM_LSB 8
`define SSH_CMD_SEL_LSB 16
`define SSH_CMD_WAKE 24
`endif

// ### core/ssh_page_mem.v
// sixteen-entry special-page register store with registered read data
`timescale 1ns/1ps
module ssh_page_mem (
    input wire pclk,
    input wire presetn,
    input wire wr_en,
    input wire [3:0] wr_sel,
    input wire [7:0] wr_data,
    input wire [3:0] rd_sel,
    output reg [7:0] rd_data
);
`include "ssh_defines.vh"
reg [7:0] mem [0:15];
genvar gi;
// ********************************
// storage, one register per entry
// ********************************
generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_ent
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mem[gi] <= `SSH_PAGE_RST;
            end else if (wr_en && {28'h0000000, wr_sel} == gi) begin
                mem[gi] <= wr_data;
            end
        end
    end
endgenerate
// ********************************
// registered read port
// ********************************
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rd_data <= 8'h00;
    end else begin
        rd_data <= mem[rd_sel];
    end
end
endmodule // ssh_page_mem

// ### core/ssh_exec.v
// execution of subtract-with-borrow, special-page moves and halt, with apb access
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
// Function
// - immediate subtract-with-borrow: imm + ~work + borrow into work, sets zero, half, borrow
// - page write copies work into page entry 0..15 in one cycle, flags untouched
// - page read copies page entry 0..15 into work in two cycles, flags untouched
// - halt clears watchdog count and divider to zero in one cycle
// - half and borrow flags follow two's complement; borrow 1 means no borrow
module ssh_exec (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire instr_valid,
    input wire [2:0] instr_op,
    input wire [7:0] instr_imm,
    input wire [3:0] instr_sel,
    input wire wake,
    input wire wdog_tick,
    output wire instr_ready,
    output reg halted,
    output reg [7:0] work_register,
    output reg [7:0] status,
    output reg [7:0] watchdog_count,
    output reg [7:0] watchdog_divider
);
`include "ssh_defines.vh"
// ********************************
// states
// ********************************
localparam ST_IDLE = 3'b001;
localparam ST_RDWAIT = 3'b010;
localparam ST_HALT = 3'b100;
reg [2:0] state;
reg [2:0] next_state;
// ********************************
// instruction source select
// ********************************
wire apb_wr;
wire apb_rd;
wire sw_cmd;
wire [2:0] op;
wire [7:0] imm;
wire [3:0] sel;
wire go;
wire page_area;
wire [3:0] page_idx;
reg [3:0] rd_idx;
wire [7:0] page_rd_data;
assign apb_wr = psel && penable && pwrite;
assign apb_rd = psel && penable && !pwrite;
assign sw_cmd = apb_wr && paddr == `SSH_A_CMD;
assign op = sw_cmd ? pwdata[`SSH_OP_W-1:0] : instr_op;
assign imm = sw_cmd ? pwdata[`SSH_CMD_IMM_LSB+7:`SSH_CMD_IMM_LSB] : instr_imm;
assign sel = sw_cmd ? pwdata[`SSH_CMD_SEL_LSB+3:`SSH_CMD_SEL_LSB] : instr_sel;
assign go = (sw_cmd || instr_valid) && state == ST_IDLE;
assign instr_ready = state == ST_IDLE && !sw_cmd;
assign page_area = paddr[7:6] == 2'b01;
assign page_idx = paddr[5:2];
// ********************************
// subtract datapath
// ********************************
wire [8:0] sum;
wire [4:0] low_sum;
wire [7:0] inv_work;
wire cin;
assign inv_work = ~work_register;
assign cin = status[`SSH_ST_BORROW];
// ********************************
// carry chain, one full adder per bit
// ********************************
wire [8:0] carry;
wire [7:0] diff;
genvar bi;
assign carry[0] = cin;
generate
    for (bi = 0; bi < 8; bi = bi + 1) begin : g_bit
        assign diff[bi] = imm[bi] ^ inv_work[bi] ^ carry[bi];
        assign carry[bi + 1] = (imm[bi] & inv_work[bi]) | (carry[bi] & (imm[bi] ^ inv_work[bi]));
    end
endgenerate
assign sum = {carry[8], diff};
assign low_sum = {carry[4], diff[3:0]};
// ********************************
// special-page store
// ********************************
wire pg_wr_cpu;
wire pg_wr_bus;
wire pg_wr;
wire [3:0] pg_wr_sel;
wire [7:0] pg_wr_data;
assign pg_wr_cpu = go && op == `SSH_OP_PG_WR;
assign pg_wr_bus = apb_wr && page_area && !pg_wr_cpu;
assign pg_wr = pg_wr_cpu || pg_wr_bus;
assign pg_wr_sel = pg_wr_cpu ? sel : page_idx;
assign pg_wr_data = pg_wr_cpu ? work_register : pwdata[7:0];
// ********************************
// page read select
// ********************************
always @* begin
    if (go && op == `SSH_OP_PG_RD) begin
        rd_idx = sel;
    end else begin
        rd_idx = page_idx;
    end
end
// ********************************
// page store instance
// ********************************
ssh_page_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(pg_wr),
    .wr_sel(pg_wr_sel),
    .wr_data(pg_wr_data),
    .rd_sel(rd_idx),
    .rd_data(page_rd_data)
);
// ********************************
// state machine
// ********************************
always @* begin
    next_state = state;
    case (state)
        ST_IDLE: begin
            if (go && op == `SSH_OP_PG_RD) begin
                next_state = ST_RDWAIT;
            end else if (go && op == `SSH_OP_HALT) begin
                next_state = ST_HALT;
            end
        end
        ST_RDWAIT: begin
            next_state = ST_IDLE;
        end
        ST_HALT: begin
            if (wake || (apb_wr && paddr == `SSH_A_STATE && pwdata[`SSH_CMD_WAKE])) begin
                next_state = ST_IDLE;
            end
        end
        default: begin
            next_state = ST_IDLE;
        end
    endcase
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state <= ST_IDLE;
    end else begin
        state <= next_state;
    end
end
// ********************************
// halt indication
// ********************************
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        halted <= 1'b0;
    end else begin
        halted <= next_state == ST_HALT;
    end
end
// ********************************
// decoded strobes
// ********************************
wire do_sub;
wire do_halt;
wire rd_done;
wire wr_work;
wire cnt_run;
assign do_sub = go && op == `SSH_OP_SUB;
assign do_halt = go && op == `SSH_OP_HALT;
assign rd_done = state == ST_RDWAIT;
assign wr_work = apb_wr && paddr == `SSH_A_WORK;
assign cnt_run = wdog_tick && state != ST_HALT;
// ********************************
// next work register
// ********************************
reg [7:0] next_work;
always @* begin
    next_work = work_register;
    if (rd_done) begin
        next_work = page_rd_data;
    end else if (do_sub) begin
        next_work = sum[7:0];
    end else if (wr_work) begin
        next_work = pwdata[7:0];
    end
end
// ********************************
// next status flags
// ********************************
reg [7:0] next_status;
always @* begin
    next_status = status;
    if (do_sub) begin
        next_status[`SSH_ST_ZERO] = sum[7:0] == 8'h00;
        next_status[`SSH_ST_HALF] = low_sum[4];
        next_status[`SSH_ST_BORROW] = sum[8];
    end
    if (do_halt) begin
        next_status[`SSH_ST_EXP] = 1'b1;
        next_status[`SSH_ST_PWR] = 1'b0;
    end
end
// ********************************
// next watchdog count and divider
// ********************************
reg [15:0] next_wdog;
always @* begin
    next_wdog = {watchdog_count, watchdog_divider};
    if (do_halt) begin
        next_wdog = {`SSH_WDOG_RST, `SSH_DIV_RST};
    end else if (cnt_run) begin
        next_wdog = {watchdog_count, watchdog_divider} + 16'h0001;
    end
end
// ********************************
// work and status registers
// ********************************
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        work_register <= `SSH_WORK_RST;
    end else begin
        work_register <= next_work;
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        status <= `SSH_STATUS_RST;
    end else begin
        status <= next_status;
    end
end
// ********************************
// watchdog registers
// ********************************
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        watchdog_count <= `SSH_WDOG_RST;
        watchdog_divider <= `SSH_DIV_RST;
    end else begin
        watchdog_count <= next_wdog[15:8];
        watchdog_divider <= next_wdog[7:0];
    end
end
// ********************************
// register decode
// ********************************
wire known;
wire hit_cmd;
wire hit_work;
wire hit_status;
wire hit_wdog;
wire hit_state;
wire [5:0] rd_hit;
assign hit_cmd = paddr == `SSH_A_CMD;
assign hit_work = paddr == `SSH_A_WORK;
assign hit_status = paddr == `SSH_A_STATUS;
assign hit_wdog = paddr == `SSH_A_WDOG;
assign hit_state = paddr == `SSH_A_STATE;
assign known = page_area || hit_cmd || hit_work || hit_status || hit_wdog || hit_state;
assign rd_hit = {page_area, hit_cmd, hit_work, hit_status, hit_wdog, hit_state};
// ********************************
// ready and error
// ********************************
assign pready = 1'b1;
assign pslverr = psel && penable && !known;
// ********************************
// read data mux
// ********************************
always @* begin
    prdata = 32'h00000000;
    if (apb_rd) begin
        case (rd_hit)
            6'b100000: begin
                prdata = {24'h000000, page_rd_data};
            end
            6'b001000: begin
                prdata = {24'h000000, work_register};
            end
            6'b000100: begin
                prdata = {24'h000000, status};
            end
            6'b000010: begin
                prdata = {16'h0000, watchdog_count, watchdog_divider};
            end
            6'b000001: begin
                prdata = {29'h00000000, state};
            end
            default: begin
                prdata = 32'h00000000;
            end
        endcase
    end
end
endmodule // ssh_exec

// ### sim/ssh_exec_props.sv
// assertion checker for the execution block
`timescale 1ns/1ps
`include "ssh_defines.vh"
module ssh_exec_props (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire instr_valid,
    input wire instr_ready,
    input wire wake,
    input wire halted,
    input wire [2:0] instr_op,
    input wire [7:0] instr_imm,
    input wire [7:0] work_register,
    input wire [7:0] status,
    input wire [7:0] watchdog_count,
    input wire [7:0] watchdog_divider
);
    wire take = instr_valid && instr_ready;
    wire [8:0] sum = {1'b0, instr_imm} + {1'b0, ~work_register} + {8'h00, status[0]};
    wire [4:0] hsum = {1'b0, instr_imm[3:0]} + {1'b0, ~work_register[3:0]} + {4'h0, status[0]};
    reg [8:0] sub_e;
    reg half_e;
    always @(posedge pclk) begin
        sub_e <= sum;
        half_e <= hsum[4];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_sub_result: assert property (take && instr_op == `SSH_OP_SUB |=>
        work_register == sub_e[7:0] && status[0] == sub_e[8]) else $error("subtract result");
    a_sub_flags: assert property (take && instr_op == `SSH_OP_SUB |=>
        status[1] == half_e && status[2] == (work_register == 8'h00)) else $error("subtract flags");
    a_page_write: assert property (take && instr_op == `SSH_OP_PG_WR |=>
        $stable(status) && $stable(work_register)) else $error("page write side effect");
    a_page_read: assert property (take && instr_op == `SSH_OP_PG_RD |=>
        !instr_ready && $stable(status) ##1 $stable(status)) else $error("page read flags");
    a_halt_clear: assert property (take && instr_op == `SSH_OP_HALT |=>
        halted && watchdog_count == 8'h00 && watchdog_divider == 8'h00) else $error("halt clear");
    a_halt_flags: assert property (take && instr_op == `SSH_OP_HALT |=>
        status[`SSH_ST_EXP] && !status[`SSH_ST_PWR]) else $error("halt flags");
    a_halt_hold: assert property (halted && !wake && !(psel && penable && pwrite) |=> halted && !instr_ready &&
        $stable(status) && $stable({watchdog_count, watchdog_divider})) else $error("halt hold");
    a_wake_exit: assert property (halted && wake |=> !halted) else $error("wake exit");
endmodule // ssh_exec_props
bind ssh_exec ssh_exec_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .instr_valid, .instr_ready, .wake, .halted,
    .instr_op, .instr_imm, .work_register, .status, .watchdog_count, .watchdog_divider);

// ### sim/tb.sv
// self-checking bench for the execution block
`timescale 1ns/1ps
`include "ssh_defines.vh"
module tb;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0, wake = 0, wdog_tick = 0;
    reg [7:0] paddr = 8'h00, instr_imm = 8'h00;
    reg [31:0] pwdata = 32'h0, rd;
    reg [2:0] instr_op = 3'h0;
    reg [3:0] instr_sel = 4'h0;
    reg err, rdy;
    wire [31:0] prdata;
    wire pready, pslverr, instr_ready, halted;
    wire [7:0] work_register, status, watchdog_count, watchdog_divider;
    integer err_count = 0, n_compared = 0, cyc = 0, w = 0, st = 8'h18, k, r, n, h;
    integer pg [0:15];
    always #2.5 pclk = ~pclk;
    ssh_exec DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .instr_valid, .instr_op, .instr_imm, .instr_sel, .wake, .wdog_tick, .instr_ready, .halted,
        .work_register, .status, .watchdog_count, .watchdog_divider);
    task report_and_stop;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [47:0] name, input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("wrong value %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task chk_core;
        begin
            chk("work", work_register, w);
            chk("status", status, st);
        end
    endtask
    task apb(input wr, input [7:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            err = pslverr;
            rdy = pready;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task exec(input [2:0] op, input [7:0] imm, input [3:0] sel);
        begin
            instr_op <= op;
            instr_imm <= imm;
            instr_sel <= sel;
            instr_valid <= 1'b1;
            @(posedge pclk);
            while (instr_ready !== 1'b1) @(posedge pclk);
            instr_valid <= 1'b0;
            @(posedge pclk);
            if (op == `SSH_OP_PG_RD) @(posedge pclk);
        end
    endtask
    always @(posedge pclk) wdog_tick <= ^$urandom;
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc > 20000) begin
            err_count = err_count + 1;
            report_and_stop;
        end
    end
    initial begin
        r = $urandom(85);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_core;
        chk("halted", halted, 0);
        for (k = 0; k < 48; k = k + 1) begin
            r = (k < 4) ? 5 + k % 2 : $urandom % 256;
            if (k < 40) exec(`SSH_OP_SUB, r[7:0], 4'h0);
            else apb(1'b1, `SSH_A_CMD, {12'h000, 4'h0, r[7:0], 5'h00, `SSH_OP_SUB});
            n = r + (~w & 255) + (st & 1);
            h = (r & 15) + (~w & 15) + (st & 1);
            w = n & 255;
            st = (st & 8'h18) | (n >> 8) | ((h >> 4) << 1) | ((w == 0) << 2);
            chk_core;
        end
        apb(1'b0, `SSH_A_WORK, 32'h0);
        chk("rdwork", rd, w);
        chk("pready", rdy, 1);
        apb(1'b0, `SSH_A_STATUS, 32'h0);
        chk("rdstat", rd, st);
        for (k = 0; k < 16; k = k + 1) begin
            w = $urandom % 256;
            apb(1'b1, `SSH_A_WORK, w);
            exec(`SSH_OP_PG_WR, 8'h00, k[3:0]);
            pg[k] = w;
            chk_core;
        end
        for (k = 15; k >= 0; k = k - 1) begin
            apb(1'b0, `SSH_A_PAGE | {2'b00, k[3:0], 2'b00}, 32'h0);
            chk("page", rd, pg[k]);
            exec(`SSH_OP_PG_RD, 8'h00, k[3:0]);
            w = pg[k];
            chk_core;
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", err, 1);
        exec(`SSH_OP_HALT, 8'h00, 4'h0);
        st = (st & 8'h07) | 8'h10;
        chk("wdog", {watchdog_count, watchdog_divider}, 0);
        chk("halted", halted, 1);
        chk_core;
        instr_op <= `SSH_OP_SUB;
        instr_valid <= 1'b1;
        repeat (5) @(posedge pclk);
        chk_core;
        chk("wdog", {watchdog_count, watchdog_divider}, 0);
        instr_valid <= 1'b0;
        wake <= 1'b1;
        @(posedge pclk);
        wake <= 1'b0;
        @(posedge pclk);
        chk("halted", halted, 0);
        chk_core;
        apb(1'b1, `SSH_A_CMD, {29'h00000000, `SSH_OP_HALT});
        chk("halted", halted, 1);
        chk_core;
        apb(1'b0, `SSH_A_STATE, 32'h0);
        chk("state", rd, 4);
        apb(1'b1, `SSH_A_STATE, 32'h01000000);
        chk("halted", halted, 0);
        chk_core;
        report_and_stop;
    end
endmodule // tb
